// ===== hdl/flyback_fault_protection_fsm.sv
// Fault-protection sequencer that gates the power switch drive.
// Assumes all sense inputs are synchronous to ref_clk and that the
// sample strobes are single-cycle pulses inside the matching interval.
`default_nettype none

module flyback_fault_protection_fsm #(
	parameter int UV_CYCLES = fault_fsm_pkg::UV_CYCLES,
	parameter int SHORT_CYCLES = fault_fsm_pkg::SHORT_CYCLES
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire fault_fsm_pkg::sense_t sense,
	output var logic gate_drive,
	output var fault_fsm_pkg::status_t status
);

	localparam int TW = fault_fsm_pkg::TIMER_W;
	localparam int CW = fault_fsm_pkg::CYCLE_W;
	localparam logic [CW-1:0] CYCLE_LAST = CW'(fault_fsm_pkg::CYCLE_TRIP_COUNT - 1);
	localparam logic [TW-1:0] UV_LAST = TW'(UV_CYCLES - 1);
	localparam logic [TW-1:0] SHORT_LAST = TW'(SHORT_CYCLES - 1);
	localparam logic [fault_fsm_pkg::BLANK_W-1:0] BLANK_LOAD =
		fault_fsm_pkg::BLANK_W'(fault_fsm_pkg::LEB_CYCLES - 1);

	fault_fsm_pkg::seq_state_t state;
	fault_fsm_pkg::seq_state_t next_state;
	fault_fsm_pkg::fault_t next_fault;
	logic any_trip;
	logic [CW-1:0] ov_cnt;
	logic [CW-1:0] sat_cnt;
	logic [CW-1:0] bo_cnt;
	logic [TW-1:0] uv_tmr;
	logic [TW-1:0] short_tmr;
	logic uv_low;
	logic short_low;
	logic [fault_fsm_pkg::BLANK_W-1:0] blank_cnt;
	logic cs_max_seen;
	logic test_fired;
	logic otp_lock;
	logic pulse_end;
	logic switching;

	// Counter step: advance on a violation, clear on a clean sample
	function automatic logic [CW-1:0] step_count(input logic [CW-1:0] cnt, input logic bad);
		step_count = bad ? cnt + 2'h1 : 2'h0;
	endfunction : step_count

	// Current sense only counts once blanking is over
	assign switching = (state == fault_fsm_pkg::ST_TEST_PULSE) || (state == fault_fsm_pkg::ST_RUN);
	assign pulse_end = gate_drive && (blank_cnt == fault_fsm_pkg::BLANK_RESET) && sense.cs_peak;

	// Trip evaluation; several faults in one cycle are all recorded
	always_comb
	begin
		next_fault = fault_fsm_pkg::FAULT_NONE;
		if (switching)
		begin
			next_fault.supply_overvoltage_trip = sense.supply_overvoltage;
			next_fault.over_temp_trip = sense.over_temp;
		end
		if (state == fault_fsm_pkg::ST_TEST_PULSE)
		begin
			// One bus sample from the test pulse decides start-up
			next_fault.brown_in_fail = sense.primary_sample && gate_drive
				&& !sense.bus_above_brown_in;
		end
		if (state == fault_fsm_pkg::ST_RUN)
		begin
			next_fault.output_overvoltage_trip = sense.secondary_sample && sense.out_high
				&& (ov_cnt == CYCLE_LAST);
			next_fault.output_undervoltage_trip = uv_low && (uv_tmr == UV_LAST);
			next_fault.output_short_trip = short_low && (short_tmr == SHORT_LAST);
			next_fault.saturation_trip = pulse_end && (cs_max_seen || sense.cs_max)
				&& (sat_cnt == CYCLE_LAST);
			next_fault.brown_out_trip = sense.primary_sample && sense.bus_below_brown_out
				&& (bo_cnt == CYCLE_LAST);
		end
		any_trip = |next_fault;
	end

	// Sequencer next state
	always_comb
	begin
		next_state = state;
		case (state)
			fault_fsm_pkg::ST_WAIT_START:
			begin
				if (sense.startup_supply_level && !otp_lock && !sense.over_temp)
					next_state = fault_fsm_pkg::ST_TEST_PULSE;
			end
			fault_fsm_pkg::ST_TEST_PULSE:
			begin
				if (any_trip)
					next_state = fault_fsm_pkg::ST_RECOVER;
				else if (sense.primary_sample && gate_drive)
					next_state = fault_fsm_pkg::ST_RUN;
			end
			fault_fsm_pkg::ST_RUN:
			begin
				if (any_trip)
					next_state = fault_fsm_pkg::ST_RECOVER;
			end
			fault_fsm_pkg::ST_RECOVER:
			begin
				if (sense.min_operating_supply)
					next_state = fault_fsm_pkg::ST_WAIT_START;
			end
			default:
				next_state = fault_fsm_pkg::ST_RECOVER;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
			state <= fault_fsm_pkg::ST_WAIT_START;
		else
			state <= next_state;
	end

	// Gate drive; a trip drops it on the same edge that leaves the state
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			gate_drive <= 1'b0;
		else if (any_trip || next_state == fault_fsm_pkg::ST_RECOVER)
			gate_drive <= 1'b0;
		else if (next_state == fault_fsm_pkg::ST_WAIT_START)
			gate_drive <= 1'b0;
		else if (pulse_end)
			gate_drive <= 1'b0;
		else if (!gate_drive && sense.turn_on_req && state == fault_fsm_pkg::ST_RUN)
			gate_drive <= 1'b1;
		else if (!gate_drive && sense.turn_on_req && state == fault_fsm_pkg::ST_TEST_PULSE
			&& !test_fired)
			gate_drive <= 1'b1;
	end

	// Only one test pulse per start attempt
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			test_fired <= 1'b0;
		else if (state != fault_fsm_pkg::ST_TEST_PULSE)
			test_fired <= 1'b0;
		else if (gate_drive)
			test_fired <= 1'b1;
	end

	// Blanking counter, reloaded at every turn-on
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			blank_cnt <= fault_fsm_pkg::BLANK_RESET;
		else if (!gate_drive)
			blank_cnt <= BLANK_LOAD;
		else if (blank_cnt != fault_fsm_pkg::BLANK_RESET)
			blank_cnt <= blank_cnt - 7'h01;
	end

	// Maximum-current flag per pulse, blind during blanking
	always_ff @(posedge ref_clk)
	begin
		if (reset || !gate_drive)
			cs_max_seen <= 1'b0;
		else if (blank_cnt == fault_fsm_pkg::BLANK_RESET && sense.cs_max)
			cs_max_seen <= 1'b1;
	end

	// Consecutive-cycle counters, only armed while running
	always_ff @(posedge ref_clk)
	begin
		if (reset || any_trip || state != fault_fsm_pkg::ST_RUN)
		begin
			ov_cnt <= fault_fsm_pkg::CYCLE_RESET;
			sat_cnt <= fault_fsm_pkg::CYCLE_RESET;
			bo_cnt <= fault_fsm_pkg::CYCLE_RESET;
		end
		else
		begin
			if (sense.secondary_sample)
				ov_cnt <= step_count(ov_cnt, sense.out_high);
			if (pulse_end)
				sat_cnt <= step_count(sat_cnt, cs_max_seen || sense.cs_max);
			if (sense.primary_sample)
				bo_cnt <= step_count(bo_cnt, sense.bus_below_brown_out);
		end
	end

	// Latest secondary-sample verdicts hold between samples
	always_ff @(posedge ref_clk)
	begin
		if (reset || any_trip || state != fault_fsm_pkg::ST_RUN)
		begin
			uv_low <= 1'b0;
			short_low <= 1'b0;
		end
		else if (sense.secondary_sample)
		begin
			uv_low <= sense.out_low;
			short_low <= sense.out_short;
		end
	end

	// Debounce timers; a clean sample restarts them from zero
	always_ff @(posedge ref_clk)
	begin
		if (reset || any_trip || !uv_low)
			uv_tmr <= fault_fsm_pkg::TIMER_RESET;
		else
			uv_tmr <= uv_tmr + 25'h000_0001;
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset || any_trip || !short_low)
			short_tmr <= fault_fsm_pkg::TIMER_RESET;
		else
			short_tmr <= short_tmr + 25'h000_0001;
	end

	// Thermal lock; a new over-temperature wins over the recovery
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			otp_lock <= 1'b0;
		else if (sense.over_temp)
			otp_lock <= 1'b1;
		else if (sense.temp_recovered)
			otp_lock <= 1'b0;
	end

	// Status; the fault record stays readable through recovery
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			status <= '0;
		else
		begin
			status.running <= (next_state == fault_fsm_pkg::ST_RUN);
			status.recovering <= (next_state == fault_fsm_pkg::ST_RECOVER);
			status.otp_locked <= sense.over_temp || (otp_lock && !sense.temp_recovered);
			if (any_trip)
				status.fault <= next_fault;
			else if (state == fault_fsm_pkg::ST_WAIT_START
				&& next_state == fault_fsm_pkg::ST_TEST_PULSE)
				status.fault <= fault_fsm_pkg::FAULT_NONE;
		end
	end

	AST_SUPPLY_OV_OFF: assert property (@(posedge ref_clk) disable iff (reset)
		(switching && sense.supply_overvoltage) |=> (!gate_drive
		&& state == fault_fsm_pkg::ST_RECOVER
		&& status.fault.supply_overvoltage_trip))
		else $error("supply overvoltage did not stop drive");

	AST_OV_THREE: assert property (@(posedge ref_clk) disable iff (reset)
		(state == fault_fsm_pkg::ST_RUN && sense.secondary_sample && sense.out_high
		&& ov_cnt == 2'h2) |=> (state == fault_fsm_pkg::ST_RECOVER
		&& status.fault.output_overvoltage_trip))
		else $error("third high sample did not trip");

	AST_UV_TIME: assert property (@(posedge ref_clk) disable iff (reset)
		(state == fault_fsm_pkg::ST_RUN && uv_low && uv_tmr == UV_LAST)
		|=> status.fault.output_undervoltage_trip)
		else $error("undervoltage debounce did not trip");

	AST_SHORT_TIME: assert property (@(posedge ref_clk) disable iff (reset)
		(state == fault_fsm_pkg::ST_RUN && short_low && short_tmr == SHORT_LAST)
		|=> (status.fault.output_short_trip && !gate_drive))
		else $error("short debounce did not trip");

	AST_OTP_OFF: assert property (@(posedge ref_clk) disable iff (reset)
		(switching && sense.over_temp) |=> (!gate_drive && status.recovering))
		else $error("over-temperature did not stop drive");

	AST_OTP_HOLD: assert property (@(posedge ref_clk) disable iff (reset)
		(state == fault_fsm_pkg::ST_WAIT_START && otp_lock)
		|=> (state != fault_fsm_pkg::ST_TEST_PULSE && !gate_drive))
		else $error("pulse left while thermally locked");

	AST_BROWN_IN_FAIL: assert property (@(posedge ref_clk) disable iff (reset)
		(state == fault_fsm_pkg::ST_TEST_PULSE && gate_drive && sense.primary_sample
		&& !sense.bus_above_brown_in) |=> (state == fault_fsm_pkg::ST_RECOVER
		&& status.fault.brown_in_fail))
		else $error("failed brown-in did not stop");

	AST_RECOVER_OFF: assert property (@(posedge ref_clk) disable iff (reset)
		(state == fault_fsm_pkg::ST_RECOVER) |-> !gate_drive ##1
		(state == fault_fsm_pkg::ST_RECOVER || $past(sense.min_operating_supply)))
		else $error("recovery left early or drove the switch");

	AST_BLANKING: assert property (@(posedge ref_clk) disable iff (reset)
		(gate_drive && blank_cnt != fault_fsm_pkg::BLANK_RESET && !any_trip
		&& next_state == state) |=> gate_drive)
		else $error("pulse ended inside blanking");

	AST_CLEAN_CLEARS: assert property (@(posedge ref_clk) disable iff (reset)
		(sense.secondary_sample && !sense.out_high) |=> (ov_cnt == fault_fsm_pkg::CYCLE_RESET))
		else $error("clean sample did not clear count");

	AST_TRIP_CLEARS: assert property (@(posedge ref_clk) disable iff (reset)
		any_trip |=> (ov_cnt == 2'h0 && bo_cnt == 2'h0 && sat_cnt == 2'h0
		&& uv_tmr == fault_fsm_pkg::TIMER_RESET && short_tmr == fault_fsm_pkg::TIMER_RESET))
		else $error("trip left counters set");

endmodule : flyback_fault_protection_fsm

`default_nettype wire

// ===== common/fault_fsm_pkg.sv
// Package for the flyback fault-protection sequencer.
// Holds the timing constants, the state codes and the carrier structs.
// Assumes a 200 MHz core clock.
`default_nettype none

package fault_fsm_pkg;

	// Core clock
	localparam int CLK_PERIOD_NS = 5;
	localparam int CLK_CYCLES_PER_MS = 1000000 / CLK_PERIOD_NS;

	// Leading-edge blanking, a least time, so it rounds up
	localparam int LEB_TIME_NS = 420;
	localparam int LEB_CYCLES = (LEB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BLANK_W = 7;

	// Debounce times
	localparam int UV_TIME_MS = 128;
	localparam int SHORT_TIME_MS = 64;
	localparam int UV_CYCLES = UV_TIME_MS * CLK_CYCLES_PER_MS;
	localparam int SHORT_CYCLES = SHORT_TIME_MS * CLK_CYCLES_PER_MS;
	localparam int TIMER_W = 25;

	// Consecutive-cycle fault counts
	localparam int CYCLE_TRIP_COUNT = 3;
	localparam int CYCLE_W = 2;

	// Values after reset
	localparam logic [CYCLE_W-1:0] CYCLE_RESET = 2'h0;
	localparam logic [TIMER_W-1:0] TIMER_RESET = 25'h000_0000;
	localparam logic [BLANK_W-1:0] BLANK_RESET = 7'h00;

	// Sequencer states, one-hot
	typedef enum logic [3:0] {
		ST_WAIT_START = 4'h1,
		ST_TEST_PULSE = 4'h2,
		ST_RUN = 4'h4,
		ST_RECOVER = 4'h8
	} seq_state_t;

	// Record of the fault that caused the last trip
	typedef struct packed {
		logic supply_overvoltage_trip;
		logic output_overvoltage_trip;
		logic output_undervoltage_trip;
		logic output_short_trip;
		logic saturation_trip;
		logic over_temp_trip;
		logic brown_in_fail;
		logic brown_out_trip;
	} fault_t;

	localparam fault_t FAULT_NONE = 8'h00;

	// Comparator verdicts and switching events from the analog front end
	typedef struct packed {
		logic supply_overvoltage; // Supply above its overvoltage threshold
		logic out_high; // Secondary sample at or above output_high_limit
		logic out_low; // Secondary sample below output_low_limit
		logic out_short; // Secondary sample below the short level
		logic secondary_sample;   // Pulse: secondary-conduction sample is valid
		logic primary_sample;     // Pulse: primary-conduction bus sample is valid
		logic bus_above_brown_in; // Bus sample above brown_in_level
		logic bus_below_brown_out;// Bus sample below brown_out_level
		logic cs_peak;            // Current sense reached the regulation peak
		logic cs_max;             // Current sense above the maximum threshold
		logic over_temp;          // Junction above the over-temperature threshold
		logic temp_recovered;     // Junction has fallen by the hysteresis
		logic startup_supply_level;
		logic min_operating_supply;// Supply has decayed to its minimum level
		logic turn_on_req;        // Pulse: regulation loop asks for a pulse
	} sense_t;

	typedef struct packed {
		logic running;
		logic recovering;
		logic otp_locked;
		fault_t fault;
	} status_t;

endpackage : fault_fsm_pkg

`default_nettype wire

// ===== bench/power_stage_model.sv
// Behavioural flyback stage and comparator front end for the fault sequencer.
// Assumes a bench that sets the comparator levels and the current ramp length.
`default_nettype none

module power_stage_model (
	input wire logic ref_clk,
	input wire logic gate_drive,
	input wire fault_fsm_pkg::sense_t levels,
	input wire logic [6:0] peak_dly,
	output var fault_fsm_pkg::sense_t sense
);
	timeunit 1ns;
	timeprecision 1ps;
	int hi_cnt = 0;
	int lo_cnt = 0;
	logic pri = 1'b0;
	logic sec = 1'b0;
	logic peak = 1'b0;
	logic ton = 1'b0;

	// Conduction phase timing, moved just after the edge like any driver
	always @(posedge ref_clk)
	begin
		#1;
		hi_cnt = gate_drive ? hi_cnt + 1 : 0;
		lo_cnt = gate_drive ? 0 : lo_cnt + 1;
		pri = gate_drive && hi_cnt == 2;
		sec = lo_cnt == 3;
		peak = gate_drive && hi_cnt >= int'(peak_dly);
		ton = lo_cnt % 40 == 30; // Loop asks for a pulse after 30 idle cycles, then every 40
	end

	// Sampled levels mean nothing off their strobe, so show the inverse there
	always_comb
	begin
		sense = levels;
		sense.primary_sample = pri;
		sense.secondary_sample = sec;
		sense.turn_on_req = ton;
		sense.cs_peak = peak;
		sense.cs_max = levels.cs_max && gate_drive;
		sense.out_high = sec ? levels.out_high : ~levels.out_high;
		sense.out_low = sec ? levels.out_low : ~levels.out_low;
		sense.out_short = sec ? levels.out_short : ~levels.out_short;
		sense.bus_above_brown_in = pri ? levels.bus_above_brown_in : ~levels.bus_above_brown_in;
		sense.bus_below_brown_out = pri ? levels.bus_below_brown_out : ~levels.bus_below_brown_out;
	end
endmodule : power_stage_model

`default_nettype wire

// ===== bench/flyback_fault_protection_fsm_tb.sv
// Self-checking bench for the flyback fault sequencer.
// Assumes the stage model in power_stage_model.sv and short debounce counts.
`default_nettype none

module flyback_fault_protection_fsm_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int UV_N = 40;
	localparam int SC_N = 20;
	// The model raises the peak early, so every clean pulse lasts the whole blanking time
	localparam int LEB_N = fault_fsm_pkg::LEB_CYCLES;
	localparam logic [14:0] KNOB [7] = '{15'h4000, 15'h2000, 15'h1000, 15'h1800,
		15'h0020, 15'h0010, 15'h0080};
	localparam logic [7:0] FLT [7] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h01};
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic gate_drive;
	logic [6:0] peak_dly = 7'h0a;
	logic was_rec = 1'b0;
	fault_fsm_pkg::sense_t sense;
	fault_fsm_pkg::sense_t lv = '0;
	fault_fsm_pkg::status_t status;
	fault_fsm_pkg::fault_t exp_q[$];
	int num_errors = 0;
	int checks = 0;
	int seed = 20689;
	int cyc = 0;
	int kcyc = 0;
	int tcyc = 0;
	int fsec = 0;
	int sec_n = 0;
	int pri_n = 0;
	int pulses = 0;
	int hi_len = 0;

	always #2.5 ref_clk = ~ref_clk;

	flyback_fault_protection_fsm #(
		.UV_CYCLES(UV_N),
		.SHORT_CYCLES(SC_N)
	) flyback_fault_protection_fsm_inst (
		.ref_clk(ref_clk),
		.reset(reset),
		.sense(sense),
		.gate_drive(gate_drive),
		.status(status)
	);

	power_stage_model power_stage_model_inst (
		.ref_clk(ref_clk),
		.gate_drive(gate_drive),
		.levels(lv),
		.peak_dly(peak_dly),
		.sense(sense)
	);

	task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
		checks++;
		if (seen !== want)
		begin
			num_errors++;
			$display("[ERR] %0t %s: seen %0h want %0h", $time, what, seen, want);
		end
	endtask : check

	task automatic summarize();
		$display("Errors %0d, checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize

	// Waits on a status flag with a bound; a hang ends the run
	task automatic wait_flag(input bit run);
		int n;
		n = 0;
		while ((run ? status.running : status.recovering) !== 1'b1 && n < 3000)
		begin
			@(negedge ref_clk);
			n++;
		end
		check(n < 3000, 1, "status wait ran out");
		if (n >= 3000)
			summarize();
		@(posedge ref_clk);
		#1;
	endtask : wait_flag

	task automatic wait_sec(input int n);
		int k;
		sec_n = 0;
		k = 0;
		while (sec_n < n && k < 1000)
		begin
			@(negedge ref_clk);
			k++;
		end
		check(sec_n >= n, 1, "no output sample");
		if (k >= 1000)
			summarize();
		@(posedge ref_clk);
		#1;
	endtask : wait_sec

	// Recovery must hold the switch off until the supply has decayed
	task automatic recover();
		pulses = 0;
		repeat (100) @(negedge ref_clk);
		check(pulses, 0, "drive while recovering");
		check(status.recovering, 1'b1, "recovery left early");
		@(posedge ref_clk);
		#1 lv.min_operating_supply = 1'b1;
		@(posedge ref_clk);
		#1 lv.min_operating_supply = 1'b0;
	endtask : recover

	// Result watcher: events, pulse widths and the fault record at each trip
	always @(negedge ref_clk)
	begin
		cyc++;
		if (sense.secondary_sample)
		begin
			if (sec_n == 0)
				fsec = cyc;
			sec_n++;
		end
		if (sense.primary_sample)
			pri_n++;
		if (gate_drive)
			hi_len++;
		else if (hi_len != 0)
		begin
			if (!status.recovering)
				check(hi_len >= LEB_N && hi_len <= LEB_N + 3, 1, "pulse width");
			pulses++;
			hi_len = 0;
		end
		if (status.recovering && !was_rec)
		begin
			tcyc = cyc;
			if (exp_q.size() == 0)
				check(0, 1, "trip without cause");
			else
				check(status.fault, exp_q.pop_front(), "fault record");
			check(gate_drive, 1'b0, "drive after trip");
		end
		was_rec = status.recovering;
	end

	// Main sequence: brown-in fail, then one trip per fault kind from a table
	initial
	begin
		repeat (16) @(posedge ref_clk);
		#1 reset = 1'b0;
		lv.startup_supply_level = 1'b1;
		exp_q.push_back(fault_fsm_pkg::fault_t'(8'h02));
		wait_flag(1'b0);
		check(pulses, 1, "test pulse count");
		lv.bus_above_brown_in = 1'b1;
		recover();
		wait_flag(1'b1);
		for (int i = 0; i < 7; i++)
		begin
			peak_dly = 7'($random(seed) & 63) + 7'h01;
			if (i == 1)
			begin
				// Two bad samples, one clean: the count must start over
				lv = fault_fsm_pkg::sense_t'(lv | KNOB[i]);
				wait_sec(2);
				lv = fault_fsm_pkg::sense_t'(lv & ~KNOB[i]);
				wait_sec(1);
			end
			lv = fault_fsm_pkg::sense_t'(lv | KNOB[i]);
			sec_n = 0;
			pri_n = 0;
			pulses = 0;
			kcyc = cyc;
			exp_q.push_back(fault_fsm_pkg::fault_t'(FLT[i]));
			wait_flag(1'b0);
			lv = fault_fsm_pkg::sense_t'(lv & ~KNOB[i]);
			if (i == 0)
				check(tcyc - kcyc <= 3, 1, "slow supply stop");
			if (i == 1)
				check(sec_n, 3, "high sample count");
			if (i == 2)
				check(tcyc - fsec >= UV_N && tcyc - fsec <= UV_N + 4, 1, "low time");
			if (i == 3)
				check(tcyc - fsec >= SC_N && tcyc - fsec <= SC_N + 4, 1, "short time");
			if (i == 4)
				check(pulses, 3, "saturated pulses");
			if (i == 5)
				check(tcyc - kcyc <= 3, 1, "slow thermal stop");
			if (i == 6)
				check(pri_n, 3, "brown-out samples");
			recover();
			if (i == 5)
			begin
				// Still hot: no pulse may appear until the hysteresis is met
				pulses = 0;
				repeat (300) @(negedge ref_clk);
				check(pulses, 0, "drive while hot");
				check(status.otp_locked, 1'b1, "thermal lock");
				@(posedge ref_clk);
				#1 lv.temp_recovered = 1'b1;
			end
			wait_flag(1'b1);
			lv.temp_recovered = 1'b0;
		end
		summarize();
	end
endmodule : flyback_fault_protection_fsm_tb

`default_nettype wire
